// file: sar_seq_pkg.sv
`default_nettype none
package sar_seq_pkg;

  // ==========================================================
  // Word format and sequence lengths
  // ==========================================================
  localparam int unsigned RESULT_BITS = 18;
  localparam int unsigned CHANNELS = 2;
  localparam logic [4:0] MSB_IDX = 5'h11;
  localparam logic [4:0] LAST_EDGE_COUNT = 5'h12;
  localparam logic [4:0] EDGE_COUNT_RESET = 5'h00;
  localparam logic [4:0] FIRST_EDGE = 5'h00;
  localparam logic [17:0] WORD_RESET = 18'h0_0000;

  // Two's complement reference codes
  localparam logic [17:0] CODE_POS_FULL = 18'h1_FFFF;
  localparam logic [17:0] CODE_ZERO = 18'h0_0000;
  localparam logic [17:0] CODE_ZERO_M1 = 18'h3_FFFF;
  localparam logic [17:0] CODE_NEG_FULL = 18'h2_0000;

  // ==========================================================
  // Types
  // ==========================================================
  typedef enum logic [0:0] {
    PH_TRACK = 1'b0,
    PH_CONVERT = 1'b1
  } phase_t;

  typedef logic [CHANNELS-1:0][RESULT_BITS-1:0] chan_words_t;

  typedef struct packed {
    phase_t phase;
    logic [4:0] edges;
    chan_words_t word;
    logic [CHANNELS-1:0] pend;
    logic [CHANNELS-1:0] ser;
    chan_words_t result;
    logic valid;
  } seq_state_t;

  typedef struct packed {
    logic convert_rise;
    logic clock_rise;
    logic [CHANNELS-1:0] keep;
  } seq_events_t;

endpackage
`default_nettype wire

// file: pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic mclk_in,
  input wire logic arst_n_in,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_out,
  output logic [WIDTH-1:0] rise_out
);

  // ==========================================================
  // Two-stage synchroniser plus edge stage
  // ==========================================================
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
    logic [WIDTH-1:0] prev;
  } sync_state_t;

  sync_state_t st;
  sync_state_t next_st;

  // Only the second stage looks at the first
  always_comb begin
    next_st.meta = pin_in;
    next_st.sync = st.meta;
    next_st.prev = st.sync;
  end

  // Constant reset matches the idle-low pins, so no false edge follows it
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Edges found on synchronised copies only
  assign level_out = st.sync;
  assign rise_out = st.sync & ~st.prev;

endmodule
`default_nettype wire

// file: dual_sar_adc_conversion_sequencer.sv
// Function
// [RQ1] Results are 18-bit two's complement, sign bit first.
// [RQ2] Each channel resolves 18 bits, 262,144 codes.
// [RQ3] A rising convert edge starts a new conversion.
// [RQ4] Host may drop convert any time before 19th clock edge.
// [RQ5] Only rising bit clock edges act; duty cycle is irrelevant.
// [RQ6] Host captures output data on rising bit clock edges.
// [RQ7] Host gives at least 19 clock edges per conversion.
// [RQ8] After the 19th edge further clock edges are ignored.
// [RQ9] From the 19th edge until next convert the device tracks.
// [RQ10] Host should stop the clock during acquisition.
// [RQ11] MSB decided on first clock edge after convert; host keeps guard.
// [RQ12] Host runs sample rate between about 48 and 222 kHz.
// [RQ13] Interval between conversions has no upper limit.
// [RQ14] Both channels enter hold together on the convert edge.
// [RQ15] One shared sequencer decides bits MSB to LSB, one per edge.
// [RQ16] Each channel's decision appears serially one clock later.
// [RQ17] Serial outputs hold the last bit until next conversion.
`timescale 1ns/10ps
`default_nettype none
module dual_sar_adc_conversion_sequencer
  import sar_seq_pkg::*;
(
  input wire logic mclk_in,
  input wire logic arst_n_in,
  input wire logic convert_in,
  input wire logic conversion_bit_clock_in,
  input wire logic comparator_left_in,
  input wire logic comparator_right_in,
  output logic hold_out,
  output logic serial_left_out,
  output logic serial_right_out,
  output logic [RESULT_BITS-1:0] result_left_out,
  output logic [RESULT_BITS-1:0] result_right_out,
  output logic result_valid_out
);

  // ==========================================================
  // Pin synchronisation
  // ==========================================================
  logic [1:0] ctrl_rise;
  logic [CHANNELS-1:0] cmp_level;
  seq_events_t ev;
  seq_state_t st;
  seq_state_t next_st;

  // Convert and bit clock only need their rising edges; the sync costs
  // two system cycles, far below one bit period
  pin_sync #(
    .WIDTH(2)
  ) u_sync_ctrl (
    .mclk_in(mclk_in),
    .arst_n_in(arst_n_in),
    .pin_in({conversion_bit_clock_in, convert_in}),
    .level_out(),
    .rise_out(ctrl_rise)
  );

  // Comparator levels ride an identical two-flop path, so a level and
  // the clock edge it belongs to reach the sequencer in the same cycle
  pin_sync #(
    .WIDTH(CHANNELS)
  ) u_sync_cmp (
    .mclk_in(mclk_in),
    .arst_n_in(arst_n_in),
    .pin_in({comparator_right_in, comparator_left_in}),
    .level_out(cmp_level),
    .rise_out()
  );

  // Events seen by the sequencer; comparator level is the keep decision
  // [RQ5] rising edges only
  always_comb begin
    ev.convert_rise = ctrl_rise[0];
    ev.clock_rise = ctrl_rise[1];
    ev.keep = cmp_level;
  end

  // ==========================================================
  // Sequencer next state
  // ==========================================================
  // The comparator is sampled two cycles late; the host's clock period
  // is many system cycles so the decision has long settled by then.
  always_comb begin
    next_st = st;
    next_st.valid = 1'b0;
    if (ev.convert_rise) begin
      // [RQ3] start on convert edge
      // [RQ14] both channels hold together
      // A clock edge in the same cycle falls in the guard and is dropped
      // Serial pins are left alone; they keep the last bit of the old frame
      next_st.phase = PH_CONVERT;
      next_st.edges = EDGE_COUNT_RESET;
      next_st.word = '0;
      next_st.pend = '0;
    end else if (ev.clock_rise && st.phase == PH_CONVERT) begin
      next_st.edges = st.edges + 5'h01;
      for (int ch = 0; ch < CHANNELS; ch++) begin
        // [RQ16] previous decision goes out one clock later
        if (st.edges != FIRST_EDGE) begin
          next_st.ser[ch] = st.pend[ch];
        end
        // [RQ15] shared count picks the bit under test, MSB first
        // [RQ1] MSB kept means input above midpoint, so sign inverts
        if (st.edges != LAST_EDGE_COUNT) begin
          next_st.word[ch][MSB_IDX - st.edges] = ev.keep[ch] ^ (st.edges == FIRST_EDGE);
          next_st.pend[ch] = ev.keep[ch] ^ (st.edges == FIRST_EDGE);
        end
      end
      // [RQ9] 19th edge returns to track
      // [RQ2] full 18-bit word published
      if (st.edges == LAST_EDGE_COUNT) begin
        next_st.phase = PH_TRACK;
        next_st.result = st.word;
        next_st.valid = 1'b1;
      end
    end
    // [RQ8] clocks in track phase fall through untouched
    // [RQ17] serial bits simply keep their value
  end

  // ==========================================================
  // State register
  // ==========================================================
  // Reset parks both channels in track with cleared words
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st <= '{phase: PH_TRACK, edges: EDGE_COUNT_RESET, word: '0, pend: '0,
              ser: '0, result: '0, valid: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from state flops; hold_out is the one-bit phase flop,
  // the compare only names its meaning
  assign hold_out = (st.phase == PH_CONVERT);
  assign serial_left_out = st.ser[0];
  assign serial_right_out = st.ser[1];
  assign result_left_out = st.result[0];
  assign result_right_out = st.result[1];
  assign result_valid_out = st.valid;

  // ==========================================================
  // Assertions
  // ==========================================================
  // All checks run on the system clock and sleep during reset; ev is the
  // synchronised view, so the checks see what the sequencer sees
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!arst_n_in);

  a_hold_on_convert: assert property (ev.convert_rise |=> hold_out) // [RQ14]
    else $error("hold not entered on convert edge");

  a_word_cleared: assert property (ev.convert_rise |=> st.word == '0) // [RQ3]
    else $error("conversion did not restart");

  a_track_after_last: assert property ( // [RQ9]
    ev.clock_rise && !ev.convert_rise && hold_out && st.edges == LAST_EDGE_COUNT
    |=> !hold_out && result_valid_out)
    else $error("no return to track after 19th edge");

  a_lockout_stable: assert property ( // [RQ8]
    !hold_out && !ev.convert_rise |=> $stable(st.ser) && $stable(st.result))
    else $error("clock acted while locked out");

  a_msb_first: assert property ( // [RQ11]
    ev.clock_rise && !ev.convert_rise && hold_out && st.edges == FIRST_EDGE
    |=> st.word[0][RESULT_BITS-1] == !$past(ev.keep[0]) && st.edges == 5'h01)
    else $error("MSB not decided on first edge");

  a_serial_delay: assert property ( // [RQ16]
    ev.clock_rise && !ev.convert_rise && hold_out && st.edges != FIRST_EDGE
    |=> serial_right_out == $past(st.pend[1]))
    else $error("serial bit not one clock after decision");

  a_edges_bounded: assert property (hold_out |-> st.edges <= LAST_EDGE_COUNT) // [RQ15]
    else $error("edge count beyond 19");

  a_result_word: assert property (result_valid_out |-> result_left_out == st.word[0]) // [RQ2]
    else $error("result differs from resolved word");

  a_valid_pulse: assert property (result_valid_out |=> !result_valid_out) // [RQ2]
    else $error("valid longer than one cycle");

  a_serial_hold: assert property ( // [RQ17]
    !hold_out |=> $stable(serial_left_out) && $stable(serial_right_out))
    else $error("serial output moved outside a conversion");

  a_track_locked: assert property ( // [RQ8]
    !hold_out && !ev.convert_rise |=> !hold_out && !result_valid_out)
    else $error("extra clock started work while tracking");

  a_hold_until_last: assert property ( // [RQ9]
    hold_out && !ev.convert_rise && !(ev.clock_rise && st.edges == LAST_EDGE_COUNT)
    |=> hold_out)
    else $error("hold dropped before 19th edge");

  a_edge_step: assert property ( // [RQ15]
    ev.clock_rise && !ev.convert_rise && hold_out
    |=> st.edges == $past(st.edges) + 5'h01)
    else $error("edge count did not advance by one");

  a_shared_decide: assert property ( // [RQ15]
    ev.clock_rise && !ev.convert_rise && hold_out && st.edges != FIRST_EDGE
    && st.edges != LAST_EDGE_COUNT |=> st.pend == $past(ev.keep))
    else $error("channels not decided on the same edge");

  a_restart_count: assert property ( // [RQ3]
    ev.convert_rise |=> st.edges == EDGE_COUNT_RESET && st.pend == '0)
    else $error("edge count not reset by convert");

  // ==========================================================
  // Cover points
  // ==========================================================
  // Main scenarios: full frame, restart, extra clocks, negative full scale
  c_full_conversion: cover property (ev.convert_rise ##[1:1000] result_valid_out);
  c_restart: cover property (hold_out && st.edges > FIRST_EDGE && ev.convert_rise);
  c_extra_clocks: cover property (!hold_out && ev.clock_rise ##1 !hold_out);
  c_negative_full: cover property (result_valid_out && result_left_out == CODE_NEG_FULL);

endmodule
`default_nettype wire

// file: sar_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module sar_host_model
  import sar_seq_pkg::*;
(
  input wire logic mclk_in,
  input wire logic serial_left_in,
  input wire logic serial_right_in,
  output logic convert_out,
  output logic bit_clock_out,
  output logic keep_left_out,
  output logic keep_right_out
);
  logic [RESULT_BITS-1:0] seen_left;
  logic [RESULT_BITS-1:0] seen_right;
  // Bit clock high time in system cycles; a bench may shorten it
  int high_cycles = 4;
  localparam int BIT_PERIOD = 8;

  // Idle host: clock parked low
  initial begin
    convert_out = 1'b0;
    bit_clock_out = 1'b0;
    keep_left_out = 1'b0;
    keep_right_out = 1'b0;
  end

  // ==========================================================
  // One frame, 400 ns bit clock
  // ==========================================================
  task automatic run_frame(input logic [17:0] code_l, input logic [17:0] code_r,
      input int n_edges, input bit start);
    int k;
    if (start) begin
      @(negedge mclk_in) convert_out = 1'b1;
      repeat (2) @(negedge mclk_in);
      convert_out = 1'b0;
      repeat (4) @(negedge mclk_in);
    end
    for (k = 1; k <= n_edges; k++) begin
      // Comparator settles in the low half, well before the edge
      keep_left_out = (k == 1) ? ~code_l[17] : (k <= 18) ? code_l[18-k] : ~keep_left_out;
      keep_right_out = (k == 1) ? ~code_r[17] : (k <= 18) ? code_r[18-k] : ~keep_right_out;
      repeat (BIT_PERIOD - high_cycles) @(negedge mclk_in);
      bit_clock_out = 1'b1;
      if (k >= 3 && k <= 19) begin
        seen_left = {seen_left[16:0], serial_left_in};
        seen_right = {seen_right[16:0], serial_right_in};
      end
      repeat (high_cycles) @(negedge mclk_in);
      bit_clock_out = 1'b0;
    end
    // Last bit shows one clock late, so fetch it after the frame
    repeat (6) @(negedge mclk_in);
    if (n_edges >= 19) begin
      seen_left = {seen_left[16:0], serial_left_in};
      seen_right = {seen_right[16:0], serial_right_in};
    end
  endtask
endmodule
`default_nettype wire

// file: test_dual_sar_adc_conversion_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
module test_dual_sar_adc_conversion_sequencer;
  import sar_seq_pkg::*;
  logic mclk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic convert, bclk, keep_l, keep_r, hold, ser_l, ser_r, valid;
  logic [RESULT_BITS-1:0] res_l;
  logic [RESULT_BITS-1:0] res_r;
  logic hold_seen = 1'b0;
  int n_fail = 0;
  int n_tests = 0;
  int n_valid = 0;

  dual_sar_adc_conversion_sequencer dual_sar_adc_conversion_sequencer_i (
    .mclk_in(mclk_in), .arst_n_in(arst_n_in), .convert_in(convert),
    .conversion_bit_clock_in(bclk), .comparator_left_in(keep_l),
    .comparator_right_in(keep_r), .hold_out(hold), .serial_left_out(ser_l),
    .serial_right_out(ser_r), .result_left_out(res_l), .result_right_out(res_r),
    .result_valid_out(valid));

  sar_host_model sar_host_model_i (
    .mclk_in(mclk_in), .serial_left_in(ser_l), .serial_right_in(ser_r),
    .convert_out(convert), .bit_clock_out(bclk), .keep_left_out(keep_l),
    .keep_right_out(keep_r));

  // ==========================================================
  // Clock, monitors, checking
  // ==========================================================
  initial forever #25 mclk_in = ~mclk_in;

  // Count result strobes and note any hold interval
  always @(posedge mclk_in) begin
    if (valid === 1'b1) n_valid++;
    if (hold === 1'b1) hold_seen = 1'b1;
  end

  task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Full frame of n edges (19 or more) with every output judged
  task automatic frame_check(input logic [17:0] cl, input logic [17:0] cr, input int n);
    int v0;
    v0 = n_valid;
    hold_seen = 1'b0;
    sar_host_model_i.run_frame(cl, cr, n, 1'b1);
    check("left result", res_l, cl);
    check("right result", res_r, cr);
    check("left serial", sar_host_model_i.seen_left, cl);
    check("right serial", sar_host_model_i.seen_right, cr);
    check("valid count", 18'(n_valid - v0), 18'h0_0001);
    check("hold seen", {17'h0_0000, hold_seen}, 18'h0_0001);
    check("hold after", {17'h0_0000, hold}, 18'h0_0000);
  endtask

  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic test_codes();
    logic [17:0] codes [4];
    codes = '{CODE_POS_FULL, CODE_ZERO, CODE_ZERO_M1, CODE_NEG_FULL};
    // back-to-back frames give roughly a 120 kHz sample rate
    for (int i = 0; i < 4; i++) frame_check(codes[i], codes[3-i], 19);
    $display("test codes done");
  endtask

  task automatic test_lockout();
    int v0;
    frame_check(18'h1_2345, 18'h2_ABCD, 23);
    v0 = n_valid;
    hold_seen = 1'b0;
    sar_host_model_i.run_frame(18'h0_0F0F, 18'h3_0F0F, 4, 1'b0);
    check("stray valid", 18'(n_valid - v0), 18'h0_0000);
    check("stray hold", {17'h0_0000, hold_seen}, 18'h0_0000);
    check("kept result", res_l, 18'h1_2345);
    check("kept serial", {17'h0_0000, ser_r}, 18'h0_0001);
    $display("test lockout done");
  endtask

  task automatic test_restart();
    repeat (400) @(negedge mclk_in);
    sar_host_model_i.run_frame(18'h3_3333, 18'h3_3333, 5, 1'b1);
    // three of eight cycles high, near the short duty option
    sar_host_model_i.high_cycles = 3;
    frame_check(18'h0_5A5A, 18'h2_A5A5, 19);
    sar_host_model_i.high_cycles = 4;
    $display("test restart done");
  endtask

  // Main sequence
  initial begin
    repeat (4) @(negedge mclk_in);
    arst_n_in = 1'b1;
    repeat (4) @(negedge mclk_in);
    test_codes();
    test_lockout();
    test_restart();
    finish_test();
  end

  // Watchdog: the run needs about 1,520 cycles; 1 ms is over ten times that
  initial begin
    #1ms;
    n_fail++;
    finish_test();
  end
endmodule
`default_nettype wire
